// ===== include/ds1lb_pkg.sv
`default_nettype none
package ds1lb_pkg;

  // Clock and timing
  localparam longint unsigned CLK_HZ         = 64'd100_000_000;
  localparam longint unsigned PERSIST_SEC    = 64'd5;
  localparam longint unsigned RESYNC_SEC     = 64'd15;
  localparam int unsigned     PERSIST_CYCLES = 32'(PERSIST_SEC * CLK_HZ);
  localparam int unsigned     RESYNC_CYCLES  = 32'(RESYNC_SEC * CLK_HZ);

  // Error tolerance: window of received bits and mismatches allowed in it.
  // Overwrite costs about 5-6 mismatches per 1000 bits, one line error two.
  localparam int unsigned WIN_BITS  = 1000;
  localparam int unsigned ERR_LIMIT = 8;

  localparam int unsigned PAT_W   = 16;
  localparam int unsigned LEN_W   = 5;
  localparam int unsigned N_CODES = 21;
  localparam int unsigned IDX_W   = 5;

  // One bit per loopback that can be commanded
  typedef struct packed {
    logic co_net;
    logic co_cust;
    logic rpt1_cust;
    logic rpt2_net;
    logic rpt2_cust;
    logic ru_net;
    logic ru_cust;
  } loop_state_s;

  localparam loop_state_s LB_NONE      = 7'h00;
  localparam loop_state_s LB_CO_NET    = 7'h40;
  localparam loop_state_s LB_CO_CUST   = 7'h20;
  localparam loop_state_s LB_RPT1_CUST = 7'h10;
  localparam loop_state_s LB_RPT2_NET  = 7'h08;
  localparam loop_state_s LB_RPT2_CUST = 7'h04;
  localparam loop_state_s LB_RU_NET    = 7'h02;
  localparam loop_state_s LB_RU_CUST   = 7'h01;

  // Repeater loopbacks need the long resynchronisation on release
  localparam loop_state_s LB_RPT_MASK  = 7'h1C;

  // Per-side received stream: in-band bits and ESF data link bits
  typedef struct packed {
    logic bit_val;
    logic bit_valid;
    logic fbit;
    logic dl_bit;
    logic dl_valid;
  } ds1_side_s;

  // In-band pattern stored first-transmitted bit at position len-1, data-link pattern at bit 0
  typedef struct packed {
    logic [PAT_W-1:0] pat;
    logic [LEN_W-1:0] len;
    logic             dl;
    logic             cust;
    logic             down;
    loop_state_s      act;
  } code_entry_s;

  typedef struct packed {
    logic [IDX_W-1:0] code_idx;
    logic             from_cust;
    logic             down;
    loop_state_s      act;
  } code_event_s;

  localparam int unsigned EV_W = $bits(code_event_s);

  typedef enum logic [2:0] {
    ST_HUNT    = 3'b001,
    ST_QUALIFY = 3'b010,
    ST_DONE    = 3'b100
  } match_state_e;

  localparam code_entry_s CODE_TABLE [N_CODES] = '{
    '{16'h0078, 5'd7,  1'b0, 1'b0, 1'b0, LB_CO_NET},
    '{16'h0070, 5'd7,  1'b0, 1'b0, 1'b0, LB_RU_NET},
    '{16'h0038, 5'd6,  1'b0, 1'b0, 1'b0, LB_RPT2_NET},
    '{16'h0020, 5'd6,  1'b0, 1'b0, 1'b0, LB_RU_NET},
    '{16'h0004, 5'd3,  1'b0, 1'b0, 1'b1, LB_NONE},
    '{16'hFF1E, 5'd16, 1'b0, 1'b0, 1'b0, LB_CO_NET},
    '{16'hFF06, 5'd16, 1'b0, 1'b0, 1'b0, LB_RPT2_NET},
    '{16'hFF02, 5'd16, 1'b0, 1'b0, 1'b0, LB_RU_NET},
    '{16'h007E, 5'd7,  1'b0, 1'b1, 1'b0, LB_CO_CUST},
    '{16'h007C, 5'd7,  1'b0, 1'b1, 1'b0, LB_RU_CUST},
    '{16'h003C, 5'd6,  1'b0, 1'b1, 1'b0, LB_RPT1_CUST},
    '{16'h003E, 5'd6,  1'b0, 1'b1, 1'b0, LB_RPT2_CUST},
    '{16'h3F1E, 5'd16, 1'b0, 1'b1, 1'b0, LB_CO_CUST},
    '{16'h3F04, 5'd16, 1'b0, 1'b1, 1'b0, LB_RPT1_CUST},
    '{16'h3F06, 5'd16, 1'b0, 1'b1, 1'b0, LB_RPT2_CUST},
    '{16'h3F02, 5'd16, 1'b0, 1'b1, 1'b0, LB_RU_CUST},
    '{16'h0004, 5'd3,  1'b0, 1'b1, 1'b1, LB_NONE},
    '{16'hFF48, 5'd16, 1'b1, 1'b0, 1'b0, LB_RU_NET},
    '{16'hFF48, 5'd16, 1'b1, 1'b1, 1'b0, LB_RU_CUST},
    '{16'hFF24, 5'd16, 1'b1, 1'b0, 1'b1, LB_NONE},
    '{16'hFF24, 5'd16, 1'b1, 1'b1, 1'b1, LB_NONE}
  };

endpackage
`default_nettype wire

// ===== src/code_fifo.sv
`default_nettype none
module code_fifo #(
  parameter int unsigned WIDTH = 14,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);

  generate
    if (WIDTH < 1 || DEPTH < 2) begin : g_bad
      $error("code_fifo needs WIDTH >= 1 and DEPTH >= 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_q;
  logic [PTR_W-1:0] rd_q;
  logic [CNT_W-1:0] cnt_q;
  logic             push;
  logic             pop;

  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    bump = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction

  assign in_ready_out  = (cnt_q != CNT_W'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out  = mem_q[rd_q];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= bump(wr_q);
      end
      if (pop) begin
        rd_q <= bump(rd_q);
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + CNT_W'(1);
      end else if (pop && !push) begin
        cnt_q <= cnt_q - CNT_W'(1);
      end
    end
  end
endmodule
`default_nettype wire

// ===== src/ds1_loopback_code_detector.sv
`default_nettype none
module ds1_loopback_code_detector #(
  parameter int unsigned PERSIST_CYCLES = ds1lb_pkg::PERSIST_CYCLES,
  parameter int unsigned RESYNC_CYCLES  = ds1lb_pkg::RESYNC_CYCLES,
  parameter int unsigned WIN_BITS       = ds1lb_pkg::WIN_BITS,
  parameter int unsigned ERR_LIMIT      = ds1lb_pkg::ERR_LIMIT,
  parameter int unsigned FIFO_DEPTH     = 4
) (
  input  wire logic                            sys_clk_in,
  input  wire logic                            rst_in,
  input  wire ds1lb_pkg::ds1_side_s            net_in,
  input  wire ds1lb_pkg::ds1_side_s            cust_in,
  input  wire logic                            fractional_mode_in,
  output logic                                 ev_valid_out,
  input  wire logic                            ev_ready_in,
  output ds1lb_pkg::code_event_s               ev_out,
  output ds1lb_pkg::loop_state_s               loop_state_out,
  output logic                                 resync_busy_out,
  output logic                                 ident_tandem_out,
  output logic                                 diff_tandem_out,
  output logic [ds1lb_pkg::N_CODES-1:0]        code_active_out
);
  localparam int unsigned N     = ds1lb_pkg::N_CODES;
  localparam int unsigned PW    = ds1lb_pkg::PAT_W;
  localparam int unsigned IW    = ds1lb_pkg::IDX_W;
  localparam int unsigned WIN_W = $clog2(WIN_BITS + 1);
  localparam int unsigned ERR_W = $clog2(ERR_LIMIT + 2);

  generate
    if (WIN_BITS < 2 * PW || ERR_LIMIT >= WIN_BITS / 4) begin : g_bad_win
      $error("Window too short for 16-bit codes or error limit too loose");
    end
    if (PERSIST_CYCLES < 1 || RESYNC_CYCLES < 1) begin : g_bad_time
      $error("Persistence and resync counts must be at least one");
    end
    if (FIFO_DEPTH < 2) begin : g_bad_fifo
      $error("Event FIFO needs at least two entries");
    end
  endgenerate

  // Reverse bit order within len bits, for data-link codes
  function automatic logic [PW-1:0] flip(input logic [PW-1:0] p,
                                         input int unsigned len);
    logic [PW-1:0] r;
    r = '0;
    for (int unsigned k = 0; k < PW; k++) begin
      if (k < len) begin
        r[len-1-k] = p[k];
      end
    end
    return r;
  endfunction

  // True when the newest len history bits are any rotation of the pattern
  function automatic logic is_rotation(input logic [PW-1:0] h,
                                       input logic [PW-1:0] p,
                                       input int unsigned len);
    logic [2*PW-1:0] dbl;
    logic [PW-1:0]   mask;
    logic            hit;
    dbl  = {p, p};
    mask = PW'((32'h0001_0000 >> (PW - len)) - 32'h0000_0001);
    hit  = 1'b0;
    for (int unsigned r = 0; r < PW; r++) begin
      if (r < len) begin
        dbl = ({{PW{1'b0}}, p} << r) | ({{PW{1'b0}}, p} >> (len - r));
        if ((dbl[PW-1:0] & mask) == (h & mask)) begin
          hit = 1'b1;
        end
      end
    end
    return hit;
  endfunction

  // Lowest pending matcher wins the event slot
  function automatic logic [IW-1:0] first_set(input logic [N-1:0] v);
    logic [IW-1:0] idx;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = IW'(i);
      end
    end
    return idx;
  endfunction

  logic [N-1:0]           pend_q;
  logic [N-1:0]           grant;
  logic                   fifo_ready;
  logic                   push;
  logic [IW-1:0]          sel;
  ds1lb_pkg::code_event_s push_ev;
  ds1lb_pkg::loop_state_s loop_q;
  logic [31:0]            resync_q;
  logic                   frac_q;

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_match
      localparam ds1lb_pkg::code_entry_s ENT = ds1lb_pkg::CODE_TABLE[gi];
      localparam int unsigned            L   = int'(ENT.len);
      localparam logic [PW-1:0]          PAT = ENT.dl ? flip(ENT.pat, L) : ENT.pat;

      ds1lb_pkg::ds1_side_s    src;
      logic                    step;
      logic                    rx_bit;
      logic                    skip;
      logic                    ins;
      logic                    miss;
      logic                    win_end;
      logic                    win_good;
      logic [PW-1:0]           hist_q;
      logic [WIN_W-1:0]        win_q;
      logic [ERR_W-1:0]        err_q;
      logic [31:0]             persist_q;
      ds1lb_pkg::match_state_e st_q;

      // Each matcher listens only to the side its code comes from
      assign src    = ENT.cust ? cust_in : net_in;
      assign step   = ENT.dl ? src.dl_valid : src.bit_valid;
      assign rx_bit = ENT.dl ? src.dl_bit : src.bit_val;
      // Framing bit position carries no code bit; predict it instead
      assign skip   = !ENT.dl && src.fbit;
      assign ins    = skip ? hist_q[L-1] : rx_bit;
      assign miss   = !skip && (rx_bit != hist_q[L-1]);
      assign win_end  = step && (win_q == WIN_W'(WIN_BITS - 1));
      // Periodicity within tolerance plus correct pattern identity
      assign win_good = (err_q <= ERR_W'(ERR_LIMIT))
                        && is_rotation(hist_q, PAT, L);

      always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
          hist_q <= '0;
        end else if (step) begin
          hist_q <= {hist_q[PW-2:0], ins};
        end
      end

      always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
          win_q <= '0;
          err_q <= '0;
        end else if (win_end) begin
          win_q <= '0;
          err_q <= '0;
        end else if (step) begin
          win_q <= win_q + WIN_W'(1);
          // Saturate so a noisy window never wraps back to good
          if (miss && err_q != '1) begin
            err_q <= err_q + ERR_W'(1);
          end
        end
      end

      always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
          st_q      <= ds1lb_pkg::ST_HUNT;
          persist_q <= '0;
        end else begin
          case (st_q)
            ds1lb_pkg::ST_HUNT: begin
              persist_q <= '0;
              if (win_end && win_good) begin
                st_q <= ds1lb_pkg::ST_QUALIFY;
              end
            end
            ds1lb_pkg::ST_QUALIFY: begin
              if (win_end && !win_good) begin
                st_q      <= ds1lb_pkg::ST_HUNT;
                persist_q <= '0;
              end else if (persist_q == PERSIST_CYCLES - 1) begin
                st_q <= ds1lb_pkg::ST_DONE;
              end else begin
                persist_q <= persist_q + 32'h0000_0001;
              end
            end
            ds1lb_pkg::ST_DONE: begin
              // Code removed: rearm so a later resend is seen again
              if (win_end && !win_good) begin
                st_q <= ds1lb_pkg::ST_HUNT;
              end
            end
            default: begin
              st_q <= ds1lb_pkg::ST_HUNT;
            end
          endcase
        end
      end

      // One event per qualification; held until the FIFO takes it
      always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
          pend_q[gi] <= 1'b0;
        end else if (st_q == ds1lb_pkg::ST_QUALIFY && !(win_end && !win_good)
                     && persist_q == PERSIST_CYCLES - 1) begin
          pend_q[gi] <= 1'b1;
        end else if (grant[gi]) begin
          pend_q[gi] <= 1'b0;
        end
      end

      assign grant[gi]           = push && (sel == IW'(gi));
      assign code_active_out[gi] = (st_q == ds1lb_pkg::ST_DONE);
    end
  endgenerate

  assign sel  = first_set(pend_q);
  // Full FIFO stalls the loopback action, not just the report
  assign push = (pend_q != '0) && fifo_ready;

  always_comb begin
    push_ev           = '0;
    push_ev.code_idx  = sel;
    push_ev.from_cust = ds1lb_pkg::CODE_TABLE[sel].cust;
    push_ev.down      = ds1lb_pkg::CODE_TABLE[sel].down;
    push_ev.act       = ds1lb_pkg::CODE_TABLE[sel].act;
  end

  // Loopback state follows each accepted event
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      loop_q <= ds1lb_pkg::LB_NONE;
    end else if (push) begin
      if (push_ev.down) begin
        loop_q <= ds1lb_pkg::LB_NONE;
      end else begin
        loop_q <= loop_q | push_ev.act;
      end
    end
  end

  // Release of a repeater loop holds off traffic until every element
  // has had time to retrain; other releases settle within the link itself
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      resync_q <= '0;
    end else if (push && push_ev.down
                 && (loop_q & ds1lb_pkg::LB_RPT_MASK) != ds1lb_pkg::LB_NONE) begin
      resync_q <= RESYNC_CYCLES;
    end else if (resync_q != '0) begin
      resync_q <= resync_q - 32'h0000_0001;
    end
  end

  // Fractional mode: all units latch as tandem dataports
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      frac_q <= 1'b0;
    end else begin
      frac_q <= fractional_mode_in;
    end
  end

  assign loop_state_out   = loop_q;
  assign resync_busy_out  = (resync_q != '0);
  // Central office and repeaters identical, remote unit different
  assign ident_tandem_out = frac_q;
  assign diff_tandem_out  = frac_q;

  code_fifo #(
    .WIDTH(ds1lb_pkg::EV_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in   (sys_clk_in),
    .rst_in       (rst_in),
    .in_valid_in  (push),
    .in_ready_out (fifo_ready),
    .in_data_in   (push_ev),
    .out_valid_out(ev_valid_out),
    .out_ready_in (ev_ready_in),
    .out_data_out (ev_out)
  );
endmodule
`default_nettype wire

// ===== bench/ds1lb_assertions.sv
`default_nettype none
module ds1lb_checker #(
  parameter int unsigned RESYNC_CYCLES = 50
) (
  input wire logic                   sys_clk_in,
  input wire logic                   rst_in,
  input wire logic                   fractional_mode_in,
  input wire logic                   ev_valid_out,
  input wire logic                   ev_ready_in,
  input wire ds1lb_pkg::code_event_s ev_out,
  input wire ds1lb_pkg::loop_state_s loop_state_out,
  input wire logic                   resync_busy_out,
  input wire logic                   ident_tandem_out,
  input wire logic                   diff_tandem_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RC_LO = RESYNC_CYCLES;
  localparam int RC_HI = RESYNC_CYCLES + 1;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  sequence s_busy;
    resync_busy_out [*8];
  endsequence
  sequence s_held;
    ev_valid_out && $stable(ev_out);
  endsequence
  property p_ident;
    !$past(rst_in) |-> ident_tandem_out == $past(fractional_mode_in);
  endproperty
  a_ident: assert property (p_ident) else $error("ident tandem flag wrong");
  property p_diff;
    !$past(rst_in) |-> diff_tandem_out == $past(fractional_mode_in);
  endproperty
  a_diff: assert property (p_diff) else $error("diff tandem flag wrong");
  // Loops only ever drop all together
  property p_loop_clear;
    ($past(loop_state_out) & ~loop_state_out) != 7'h0 |-> loop_state_out == 7'h0;
  endproperty
  a_loop_clear: assert property (p_loop_clear) else $error("partial loop release");
  property p_loop_event;
    loop_state_out != $past(loop_state_out) |-> ##[0:1] ev_valid_out;
  endproperty
  a_loop_event: assert property (p_loop_event) else $error("loop change without event");
  property p_fifo_hold;
    ev_valid_out && !ev_ready_in |=> s_held;
  endproperty
  a_fifo_hold: assert property (p_fifo_hold) else $error("event dropped while stalled");
  property p_resync_start;
    ($past(loop_state_out) & ds1lb_pkg::LB_RPT_MASK) != 7'h0 && loop_state_out == 7'h0
      |=> s_busy;
  endproperty
  a_resync_start: assert property (p_resync_start) else $error("no resync busy");
  property p_resync_len;
    $rose(resync_busy_out) |-> ##[RC_LO:RC_HI] !resync_busy_out;
  endproperty
  a_resync_len: assert property (p_resync_len) else $error("resync length wrong");
  property p_down_none;
    ev_valid_out && ev_out.down |-> ev_out.act == 7'h0;
  endproperty
  a_down_none: assert property (p_down_none) else $error("release event sets a loop");
  property p_act_onehot;
    ev_valid_out && !ev_out.down |-> $onehot(ev_out.act);
  endproperty
  a_act_onehot: assert property (p_act_onehot) else $error("loop event not one loop");
  property p_side;
    ev_valid_out |-> (ev_out.act & (ev_out.from_cust ? 7'h4a : 7'h35)) == 7'h0;
  endproperty
  a_side: assert property (p_side) else $error("loop toward wrong side");
endmodule
`default_nettype wire

// ===== bench/ds1_test_set.sv
`default_nettype none
module ds1_test_set (
  input  wire logic            sys_clk_in,
  input  wire logic            rst_in,
  input  wire logic            send_in,
  input  wire logic [15:0]     pat_in,
  input  wire logic [4:0]      len_in,
  input  wire logic            dl_in,
  input  wire logic            ovw_in,
  output ds1lb_pkg::ds1_side_s side_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] pos_q;
  logic [7:0] fcnt_q;
  logic       cur;
  logic       fslot;
  // Index cut to four bits so a pattern change never reads past the word
  assign cur = dl_in ? pat_in[4'(pos_q)] : pat_in[4'(len_in - 5'h1 - pos_q)];
  assign fslot = ovw_in && !dl_in && fcnt_q == 8'h0;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pos_q <= 5'h0;
      fcnt_q <= 8'h0;
      side_out <= '0;
    end else if (send_in) begin
      // Wrap also when a shorter pattern arrives mid-period
      pos_q <= (pos_q >= len_in - 5'h1) ? 5'h0 : pos_q + 5'h1;
      fcnt_q <= (fcnt_q == 8'hc0) ? 8'h0 : fcnt_q + 8'h1;
      side_out.bit_valid <= !dl_in;
      side_out.dl_valid <= dl_in;
      side_out.fbit <= fslot;
      // Framing slot inverts the code bit, the harshest overwrite
      side_out.bit_val <= dl_in ? !side_out.bit_val : cur ^ fslot;
      side_out.dl_bit <= dl_in ? cur : !side_out.dl_bit;
    end else begin
      pos_q <= 5'h0;
      side_out.bit_valid <= 1'b0;
      side_out.dl_valid <= 1'b0;
      side_out.fbit <= 1'b0;
      // Idle lines toggle so a stale level never looks like code
      side_out.bit_val <= !side_out.bit_val;
      side_out.dl_bit <= !side_out.dl_bit;
    end
  end
endmodule
`default_nettype wire

// ===== bench/test_ds1_loopback_code_detector.sv
`default_nettype none
module test_ds1_loopback_code_detector;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PERSIST = 200;
  localparam int RESYNC  = 50;
  localparam int LIMIT   = 30000;
  localparam logic [15:0] PATS [21] = '{16'h0078, 16'h0070, 16'h0038, 16'h0020, 16'h0004,
    16'hff1e, 16'hff06, 16'hff02, 16'h007e, 16'h007c, 16'h003c, 16'h003e, 16'h3f1e, 16'h3f04,
    16'h3f06, 16'h3f02, 16'h0004, 16'hff48, 16'hff48, 16'hff24, 16'hff24};
  localparam logic [4:0] LENS [21] = '{5'h7, 5'h7, 5'h6, 5'h6, 5'h3, 5'h10, 5'h10, 5'h10, 5'h7,
    5'h7, 5'h6, 5'h6, 5'h10, 5'h10, 5'h10, 5'h10, 5'h3, 5'h10, 5'h10, 5'h10, 5'h10};
  localparam logic [6:0] ACTS [21] = '{7'h40, 7'h02, 7'h08, 7'h02, 7'h00, 7'h40, 7'h08, 7'h02,
    7'h20, 7'h01, 7'h10, 7'h04, 7'h20, 7'h10, 7'h04, 7'h01, 7'h00, 7'h02, 7'h01, 7'h00, 7'h00};
  localparam logic [20:0] CUST_M = 21'h15_ff00;
  localparam logic [20:0] DL_M   = 21'h1e_0000;
  localparam logic [20:0] DOWN_M = 21'h19_0010;
  logic                   sys_clk_in;
  logic                   rst_in;
  logic                   fractional_mode_in;
  logic                   ev_ready_in;
  logic [1:0]             go;
  logic [1:0]             dl;
  logic [1:0]             ovw;
  logic [15:0]            pat [2];
  logic [4:0]             len [2];
  ds1lb_pkg::ds1_side_s   net_in;
  ds1lb_pkg::ds1_side_s   cust_in;
  logic                   ev_valid_out;
  logic                   resync_busy_out;
  logic                   ident_tandem_out;
  logic                   diff_tandem_out;
  ds1lb_pkg::code_event_s ev_out;
  ds1lb_pkg::loop_state_s loop_state_out;
  logic [20:0]            code_active_out;
  int                     err_count = 0;
  int                     num_checks = 0;
  int                     cyc = 0;

  ds1_loopback_code_detector #(.PERSIST_CYCLES(PERSIST), .RESYNC_CYCLES(RESYNC), .WIN_BITS(64),
    .ERR_LIMIT(8), .FIFO_DEPTH(4)) DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .net_in(net_in), .cust_in(cust_in), .fractional_mode_in(fractional_mode_in),
    .ev_valid_out(ev_valid_out), .ev_ready_in(ev_ready_in), .ev_out(ev_out),
    .loop_state_out(loop_state_out), .resync_busy_out(resync_busy_out),
    .ident_tandem_out(ident_tandem_out), .diff_tandem_out(diff_tandem_out),
    .code_active_out(code_active_out));
  ds1_test_set net_set (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .send_in(go[0]),
    .pat_in(pat[0]), .len_in(len[0]), .dl_in(dl[0]), .ovw_in(ovw[0]), .side_out(net_in));
  ds1_test_set cust_set (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .send_in(go[1]),
    .pat_in(pat[1]), .len_in(len[1]), .dl_in(dl[1]), .ovw_in(ovw[1]), .side_out(cust_in));

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(posedge sys_clk_in);
    rst_in <= 1'b1;
    go <= 2'b00;
    repeat (10) @(posedge sys_clk_in);
    rst_in <= 1'b0;
  endtask
  task automatic send(input int i, input int s, input logic ow);
    @(posedge sys_clk_in);
    go[s] <= 1'b1;
    pat[s] <= PATS[i];
    len[s] <= LENS[i];
    dl[s] <= DL_M[i];
    ovw[s] <= ow;
  endtask
  // Negative index waits for an event, otherwise for that matcher
  task automatic wait_for(input int i, output int n);
    n = 0;
    #1;
    while (!(i < 0 ? ev_valid_out === 1'b1 : code_active_out[i] === 1'b1) && n < 1500) begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end
    chk_flag(n < 1500, 1'b1);
  endtask

  task automatic t_codes();
    int n;
    for (int i = 0; i < 21; i++) begin
      do_reset();
      send(i, int'(CUST_M[i]), i[0] & !DL_M[i]);
      wait_for(-1, n);
      chk_flag(n >= PERSIST, 1'b1);
      chk_val(ev_out.code_idx, i);
      chk_flag(ev_out.from_cust, CUST_M[i]);
      chk_flag(ev_out.down, DOWN_M[i]);
      chk_val(ev_out.act, ACTS[i]);
      chk_val(loop_state_out, ACTS[i]);
    end
    $display("code table test done");
  endtask
  task automatic t_side();
    do_reset();
    send(0, 1, 1'b0);
    repeat (900) @(posedge sys_clk_in);
    #1;
    chk_flag(ev_valid_out, 1'b0);
    chk_val({11'h0, code_active_out}, 32'h0);
    $display("wrong side test done");
  endtask
  task automatic t_down();
    int n;
    do_reset();
    send(2, 0, 1'b1);
    wait_for(-1, n);
    chk_val(loop_state_out, 32'h8);
    send(16, 1, 1'b0);
    wait_for(-1, n);
    chk_val(loop_state_out, 32'h0);
    @(posedge sys_clk_in);
    #1;
    chk_flag(resync_busy_out, 1'b1);
    repeat (RESYNC) @(posedge sys_clk_in);
    #1;
    chk_flag(resync_busy_out, 1'b0);
    $display("loop down test done");
  endtask
  // Code broken off mid-persistence must start its timer again
  task automatic t_restart();
    int n;
    do_reset();
    send(0, 0, 1'b0);
    repeat (150) @(posedge sys_clk_in);
    send(8, 0, 1'b0);
    repeat (130) @(posedge sys_clk_in);
    #1;
    chk_val(loop_state_out, 32'h0);
    send(0, 0, 1'b0);
    wait_for(-1, n);
    chk_flag(n >= PERSIST, 1'b1);
    chk_val(loop_state_out, 32'h40);
    $display("restart test done");
  endtask
  task automatic t_fifo();
    int n;
    int q [5] = '{0, 1, 2, 3, 5};
    do_reset();
    ev_ready_in <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      send(q[k], 0, 1'b0);
      wait_for(q[k], n);
    end
    // Fifth event is still pending behind a full buffer
    chk_val(ev_out.code_idx, 32'h0);
    chk_val(loop_state_out, 32'h4a);
    @(posedge sys_clk_in);
    go <= 2'b00;
    for (int k = 0; k < 5; k++) begin
      wait_for(-1, n);
      chk_val(ev_out.code_idx, q[k]);
      @(posedge sys_clk_in);
      ev_ready_in <= 1'b1;
      @(posedge sys_clk_in);
      ev_ready_in <= 1'b0;
    end
    #1;
    chk_flag(ev_valid_out, 1'b0);
    $display("buffer test done");
  endtask
  task automatic t_frac();
    @(posedge sys_clk_in);
    fractional_mode_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    #1;
    chk_flag(ident_tandem_out, 1'b1);
    chk_flag(diff_tandem_out, 1'b1);
    @(posedge sys_clk_in);
    fractional_mode_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    #1;
    chk_flag(ident_tandem_out, 1'b0);
    $display("fractional test done");
  endtask

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = !sys_clk_in;
  end
  initial begin
    rst_in = 1'b1;
    fractional_mode_in = 1'b0;
    ev_ready_in = 1'b1;
    go = 2'b00;
    dl = 2'b00;
    ovw = 2'b00;
    pat = '{16'h0, 16'h0};
    len = '{5'h1, 5'h1};
    do_reset();
    t_frac();
    t_codes();
    t_side();
    t_down();
    t_restart();
    t_fifo();
    conclude();
  end
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_count++;
      conclude();
    end
  end
endmodule

bind ds1_loopback_code_detector ds1lb_checker #(.RESYNC_CYCLES(RESYNC_CYCLES)) u_chk (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .fractional_mode_in(fractional_mode_in),
  .ev_valid_out(ev_valid_out), .ev_ready_in(ev_ready_in), .ev_out(ev_out),
  .loop_state_out(loop_state_out), .resync_busy_out(resync_busy_out),
  .ident_tandem_out(ident_tandem_out), .diff_tandem_out(diff_tandem_out));
`default_nettype wire
